// ### logic/fct_pkg.sv
/*
 * constants, register map and carrier types for the fringe counter and turnaround block.
 * assumes one 50 MHz clock and synchronous, active-low reset.
 */
package fct_pkg;
    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CMD     = 8'h04;
    localparam logic [7:0] ADDR_START   = 8'h08;
    localparam logic [7:0] ADDR_LATCH0  = 8'h0c;
    localparam logic [7:0] ADDR_LATCH1  = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h1c;
    localparam logic [7:0] ADDR_DISPLAY = 8'h20;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CTRL_GATE_BIT  = 0;
    localparam int CMD_LATCH_BIT  = 0;
    localparam int CMD_INIT_BIT   = 1;
    localparam int CMD_LOAD_BIT   = 2;
    localparam int STAT_DIR_BIT   = 0;
    localparam int STAT_ENDA_BIT  = 1;
    localparam int STAT_ENDB_BIT  = 2;
    localparam int IRQ_TURN_BIT   = 0;
    localparam int IRQ_ENDA_BIT   = 1;
    localparam int IRQ_ENDB_BIT   = 2;
    localparam int IRQ_W          = 3;
    localparam logic [15:0] STAGE_RST  = 16'hffff;
    localparam logic [7:0]  DISP_MASK  = 8'hf0;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] start;
        logic        armed;
        logic        tick_q;
    } fct_stage_t;
    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
    } fct_pair_t;
endpackage : fct_pkg

// ### logic/fct_top.sv
/*
 * fringe counters for two lasers, end-of-track direction latch and masked display port,
 * reached over axi4-lite.
 * assumes fringe and detector inputs synchronous to aclk, one pulse per fringe high level.
 */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
// What this block does
// - fringe pulse ANDed with gate clocks the first counter stage.
// - each stage is a 16-bit down-counter that reloads its start value from zero.
// - two stages cascade per laser, first output clocks second.
// - latch command copies current counts without disturbing counting.
// - new start value takes effect only at the stage's next pulse.
// - optional init pulse ORed into both stage clocks.
// - detector inputs high while beam clear, low while blocked.
// - detectors set/reset direction latch; software cannot alter direction.
`timescale 1ns/1ps
module fct_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  fringe_in,
    input  wire logic        end_a_clear,
    input  wire logic        end_b_clear,
    output logic             motor_dir,
    output logic [7:0]       display_port,
    output logic             irq
);
    // ****************************************
    // counter stages
    // ****************************************
    logic [1:0]        gate_ff;
    logic [1:0]        nxt_gate;
    logic              init_ff;
    logic              nxt_init;
    logic              load_ff;
    logic              nxt_load;
    logic              latch_ff;
    logic              nxt_latch;
    logic [15:0]       start_ff;
    logic [15:0]       nxt_start;
    fct_pkg::fct_stage_t st_ff  [4];
    fct_pkg::fct_stage_t nxt_st [4];
    fct_pkg::fct_pair_t  lat_ff [2];
    fct_pkg::fct_pair_t  nxt_lat[2];
    logic [3:0]        tick;
    logic [3:0]        wrap;

    always_comb
    begin
        for (int l = 0; l < 2; l++)
        begin
            tick[2*l]   = (fringe_in[l] & gate_ff[l]) | init_ff;
            wrap[2*l]   = tick[2*l] & st_ff[2*l].armed & (st_ff[2*l].cnt == 16'h0000);
            tick[2*l+1] = wrap[2*l] | init_ff;
            wrap[2*l+1] = tick[2*l+1] & st_ff[2*l+1].armed & (st_ff[2*l+1].cnt == 16'h0000);
        end
        for (int s = 0; s < 4; s++)
        begin
            nxt_st[s] = st_ff[s];
            nxt_st[s].tick_q = tick[s];
            if (tick[s])
            begin
                if (!st_ff[s].armed)
                begin
                    nxt_st[s].cnt   = st_ff[s].start;
                    nxt_st[s].armed = 1'b1;
                end
                else if (st_ff[s].cnt == 16'h0000)
                    nxt_st[s].cnt = st_ff[s].start;
                else
                    nxt_st[s].cnt = st_ff[s].cnt - 16'h0001;
            end
            if (load_ff)
            begin
                nxt_st[s].start = start_ff;
                nxt_st[s].armed = 1'b0;
            end
        end
        for (int l = 0; l < 2; l++)
        begin
            nxt_lat[l] = lat_ff[l];
            if (latch_ff)
            begin
                nxt_lat[l].lo = st_ff[2*l].cnt;
                nxt_lat[l].hi = st_ff[2*l+1].cnt;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int s = 0; s < 4; s++)
                st_ff[s] <= '{cnt: fct_pkg::STAGE_RST, start: fct_pkg::STAGE_RST, armed: 1'b0, tick_q: 1'b0};
            for (int l = 0; l < 2; l++)
                lat_ff[l] <= '{lo: 16'h0000, hi: 16'h0000};
        end
        else
        begin
            st_ff  <= nxt_st;
            lat_ff <= nxt_lat;
        end
    end

    // ****************************************
    // direction latch
    // ****************************************
    logic dir_ff;
    logic nxt_dir;
    logic end_a_lo;
    logic end_b_lo;

    always_comb
    begin
        end_a_lo = ~end_a_clear;
        end_b_lo = ~end_b_clear;
        nxt_dir  = dir_ff;
        if (end_a_lo & ~end_b_lo)
            nxt_dir = 1'b1;
        else if (end_b_lo & ~end_a_lo)
            nxt_dir = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dir_ff <= 1'b0;
        else
            dir_ff <= nxt_dir;
    end

    // ****************************************
    // interrupt status
    // ****************************************
    logic [fct_pkg::IRQ_W-1:0] ist_ff;
    logic [fct_pkg::IRQ_W-1:0] nxt_ist;
    logic [fct_pkg::IRQ_W-1:0] imsk_ff;
    logic [fct_pkg::IRQ_W-1:0] nxt_imsk;
    logic [fct_pkg::IRQ_W-1:0] ev;
    logic [fct_pkg::IRQ_W-1:0] w1c;
    logic                      end_a_q;
    logic                      end_b_q;
    logic                      irq_ff;

    always_comb
    begin
        ev[fct_pkg::IRQ_TURN_BIT] = nxt_dir != dir_ff;
        ev[fct_pkg::IRQ_ENDA_BIT] = end_a_lo & ~end_a_q;
        ev[fct_pkg::IRQ_ENDB_BIT] = end_b_lo & ~end_b_q;
        nxt_ist = (ist_ff & ~w1c) | ev;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ist_ff  <= '0;
            imsk_ff <= '0;
            end_a_q <= 1'b0;
            end_b_q <= 1'b0;
            irq_ff  <= 1'b0;
        end
        else
        begin
            ist_ff  <= nxt_ist;
            imsk_ff <= nxt_imsk;
            end_a_q <= end_a_lo;
            end_b_q <= end_b_lo;
            irq_ff  <= |(nxt_ist & nxt_imsk);
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [7:0]  awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd;
    logic [3:0]  ws_ff, nxt_ws;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rd_ff, nxt_rd, wmask, wval;
    logic [7:0]  disp_ff, nxt_disp;
    logic        do_wr;
    logic        awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, ardy_ff, nxt_ardy;

    always_comb
    begin
        nxt_aw = aw_ff; nxt_awa = awa_ff;
        nxt_w  = w_ff;  nxt_wd  = wd_ff; nxt_ws = ws_ff;
        nxt_b  = b_ff;  nxt_bresp = bresp_ff;
        nxt_r  = r_ff;  nxt_rresp = rresp_ff; nxt_rd = rd_ff;
        nxt_gate = gate_ff; nxt_start = start_ff; nxt_imsk = imsk_ff; nxt_disp = disp_ff;
        nxt_init = 1'b0; nxt_load = 1'b0; nxt_latch = 1'b0;
        w1c = '0;
        if (s_axi_awvalid && !aw_ff)
        begin
            nxt_aw  = 1'b1;
            nxt_awa = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !w_ff)
        begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        for (int i = 0; i < 4; i++)
            wmask[8*i +: 8] = {8{ws_ff[i]}};
        wval  = wd_ff & wmask;
        do_wr = aw_ff && w_ff && !b_ff;
        if (do_wr)
        begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_b  = 1'b1;
            nxt_bresp = fct_pkg::RESP_OKAY;
            case (awa_ff)
                fct_pkg::ADDR_CTRL:    nxt_gate = (gate_ff & ~wmask[1:0]) | wval[1:0];
                fct_pkg::ADDR_CMD:
                begin
                    nxt_latch = wval[fct_pkg::CMD_LATCH_BIT];
                    nxt_init  = wval[fct_pkg::CMD_INIT_BIT];
                    nxt_load  = wval[fct_pkg::CMD_LOAD_BIT];
                end
                fct_pkg::ADDR_START:   nxt_start = (start_ff & ~wmask[15:0]) | wval[15:0];
                fct_pkg::ADDR_IRQ_ST:  w1c = wval[fct_pkg::IRQ_W-1:0];
                fct_pkg::ADDR_IRQ_MSK: nxt_imsk = (imsk_ff & ~wmask[fct_pkg::IRQ_W-1:0]) | wval[fct_pkg::IRQ_W-1:0];
                fct_pkg::ADDR_DISPLAY:
                    if (ws_ff[0])
                        nxt_disp = (disp_ff & ~fct_pkg::DISP_MASK) | (wd_ff[7:0] & fct_pkg::DISP_MASK);
                default: nxt_bresp = fct_pkg::RESP_SLVERR;
            endcase
        end
        if (b_ff && s_axi_bready)
            nxt_b = 1'b0;
        if (r_ff && s_axi_rready)
            nxt_r = 1'b0;
        if (s_axi_arvalid && !r_ff)
        begin
            nxt_r = 1'b1;
            nxt_rresp = fct_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                fct_pkg::ADDR_CTRL:    nxt_rd = {30'h0, gate_ff};
                fct_pkg::ADDR_START:   nxt_rd = {16'h0, start_ff};
                fct_pkg::ADDR_LATCH0:  nxt_rd = {lat_ff[0].hi, lat_ff[0].lo};
                fct_pkg::ADDR_LATCH1:  nxt_rd = {lat_ff[1].hi, lat_ff[1].lo};
                fct_pkg::ADDR_STATUS:  nxt_rd = {29'h0, end_b_lo, end_a_lo, dir_ff};
                fct_pkg::ADDR_IRQ_ST:  nxt_rd = {29'h0, ist_ff};
                fct_pkg::ADDR_IRQ_MSK: nxt_rd = {29'h0, imsk_ff};
                fct_pkg::ADDR_DISPLAY: nxt_rd = {24'h0, disp_ff};
                fct_pkg::ADDR_CMD:     nxt_rd = 32'h0000_0000;
                default:
                begin
                    nxt_rd = 32'h0000_0000;
                    nxt_rresp = fct_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_awrdy = ~nxt_aw;
        nxt_wrdy  = ~nxt_w;
        nxt_ardy  = ~nxt_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0; awa_ff <= 8'h00; w_ff <= 1'b0; wd_ff <= 32'h0; ws_ff <= 4'h0;
            awrdy_ff <= 1'b1;
            wrdy_ff  <= 1'b1;
            ardy_ff  <= 1'b1;
            b_ff <= 1'b0; bresp_ff <= 2'b00; r_ff <= 1'b0; rresp_ff <= 2'b00; rd_ff <= 32'h0;
            gate_ff <= 2'b00; start_ff <= fct_pkg::STAGE_RST; disp_ff <= 8'h00;
            init_ff <= 1'b0; load_ff <= 1'b0; latch_ff <= 1'b0;
        end
        else
        begin
            aw_ff <= nxt_aw; awa_ff <= nxt_awa; w_ff <= nxt_w; wd_ff <= nxt_wd; ws_ff <= nxt_ws;
            b_ff <= nxt_b; bresp_ff <= nxt_bresp; r_ff <= nxt_r; rresp_ff <= nxt_rresp; rd_ff <= nxt_rd;
            gate_ff <= nxt_gate; start_ff <= nxt_start; disp_ff <= nxt_disp;
            init_ff <= nxt_init; load_ff <= nxt_load; latch_ff <= nxt_latch;
            awrdy_ff <= nxt_awrdy;
            wrdy_ff  <= nxt_wrdy;
            ardy_ff  <= nxt_ardy;
        end
    end

    assign s_axi_awready = awrdy_ff;
    assign s_axi_wready  = wrdy_ff;
    assign s_axi_bvalid  = b_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ardy_ff;
    assign s_axi_rvalid  = r_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rd_ff;
    assign motor_dir     = dir_ff;
    assign display_port  = disp_ff;
    assign irq           = irq_ff;
endmodule : fct_top

// ### dv/fct_top_asserts.sv
/*
 * port assertions for fct_top.
 * assumes one clock, aclk, and synchronous active-low aresetn.
 */
`timescale 1ns/1ps
module fct_top_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        end_a_clear,
    input wire logic        end_b_clear,
    input wire logic        motor_dir,
    input wire logic [7:0]  display_port
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_dir_set_a: assert property (!end_a_clear && end_b_clear |-> ##[1:2] motor_dir)
        else $error("direction not set by end a");
    a_dir_set_b: assert property (end_a_clear && !end_b_clear |-> ##[1:2] !motor_dir)
        else $error("direction not cleared by end b");
    a_dir_hold: assert property (end_a_clear && end_b_clear && $past(end_a_clear) && $past(end_b_clear)
        |-> $stable(motor_dir)) else $error("direction moved without detector");
    a_disp_low_kept: assert property (display_port[3:0] == 4'h0)
        else $error("display lower nibble changed");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_dir_up: cover property ($rose(motor_dir));
    c_dir_down: cover property ($fell(motor_dir));
endmodule : fct_top_asserts
bind fct_top fct_top_asserts chk_u (.*);

// ### dv/fct_far_model.sv
/*
 * far side model: fringe sources and end-of-track detectors.
 * assumes bench calls its tasks; lines change just after rising aclk.
 */
`timescale 1ns/1ps
module fct_far_model #(
    parameter int BLOCK_CYC = 20
) (
    input  wire logic  aclk,
    output logic [1:0] fringe_in,
    output logic       end_a_clear,
    output logic       end_b_clear
);
    // ****************************************
    // sources
    // ****************************************
    initial
    begin
        fringe_in   = 2'h0;
        end_a_clear = 1'b1; // beam clear reads high
        end_b_clear = 1'b1;
    end
    task automatic fringes(input logic [1:0] lanes, input int n);
        repeat (n)
        begin
            @(posedge aclk);
            fringe_in <= lanes;
            @(posedge aclk);
            fringe_in <= 2'h0;
        end
    endtask : fringes
    // flag blocks one beam for a shortened window
    task automatic block(input logic which);
        @(posedge aclk);
        end_a_clear <= which;
        end_b_clear <= ~which;
        repeat (BLOCK_CYC) @(posedge aclk);
        end_a_clear <= 1'b1;
        end_b_clear <= 1'b1;
    endtask : block
endmodule : fct_far_model

// ### dv/tb_top.sv
/*
 * self-checking bench for fct_top: axi4-lite master, far model, random counts.
 * assumes fct_top_asserts is bound to the design.
 */
`timescale 1ns/1ps
module tb_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, motor_dir, irq;
    logic        end_a_clear, end_b_clear;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, fringe_in, rsp;
    logic [7:0]  display_port, d;
    logic [15:0] st;
    int          n_fail, total_checks, seed, n;
    fct_top dut_u (.*);
    fct_far_model #(.BLOCK_CYC(20)) far_u (.*);
    // ****************************************
    // clock and helpers
    // ****************************************
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        if (k == 50) n_fail++;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd_v = s_axi_rdata;
        rsp = s_axi_rresp;
        if (k == 50) n_fail++;
    endtask : axi_rd
    // both stages armed at s, then t ticks of the low stage
    function automatic logic [31:0] exp_cnt(input logic [15:0] s, input int t);
        return {s - 16'((t / (s + 1)) % (s + 1)), s - 16'(t % (s + 1))};
    endfunction : exp_cnt
    // fringe total from start and latched count, lost-count fix without init pulse
    function automatic logic [31:0] fringe_total(input logic [31:0] s, input logic [31:0] q, input logic init);
        return s - q + (init ? 32'h0000_0000 : 32'h0002_0000);
    endfunction : fringe_total
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        #200000;
        n_fail++;
        final_report();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        seed = 67301;
        n_fail = 0;
        total_checks = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(fct_pkg::ADDR_CTRL, 32'h1);
        repeat (3)
        begin
            st = 16'($unsigned($random(seed)) % 7 + 1);
            n = $unsigned($random(seed)) % 20;
            axi_wr(fct_pkg::ADDR_START, {16'h0, st});
            axi_wr(fct_pkg::ADDR_CMD, 32'h4);
            far_u.fringes(2'h3, 1);
            axi_wr(fct_pkg::ADDR_CMD, 32'h1);
            axi_rd(fct_pkg::ADDR_LATCH0);
            check({16'h0, rd_v[15:0]}, {16'h0, st});
            axi_wr(fct_pkg::ADDR_CMD, 32'h2);
            far_u.fringes(2'h3, n);
            axi_wr(fct_pkg::ADDR_CMD, 32'h1);
            repeat (2) @(posedge aclk);
            far_u.fringes(2'h3, 3);
            axi_rd(fct_pkg::ADDR_LATCH0);
            check(rd_v, exp_cnt(st, n + 1));
            axi_rd(fct_pkg::ADDR_LATCH1);
            check(rd_v, {st, st});
        end
        // full-range start, both lasers gated on
        axi_wr(fct_pkg::ADDR_CTRL, 32'h3);
        axi_wr(fct_pkg::ADDR_START, 32'h0000_ffff);
        axi_wr(fct_pkg::ADDR_CMD, 32'h4);
        check({30'h0, rsp}, {30'h0, fct_pkg::RESP_OKAY});
        axi_wr(fct_pkg::ADDR_CMD, 32'h2);
        n = $unsigned($random(seed)) % 20;
        far_u.fringes(2'h3, n);
        axi_wr(fct_pkg::ADDR_CMD, 32'h1);
        axi_rd(fct_pkg::ADDR_LATCH0);
        check(fringe_total(32'hffff_ffff, rd_v, 1'b1), n);
        axi_rd(fct_pkg::ADDR_LATCH1);
        check(fringe_total(32'hffff_ffff, rd_v, 1'b1), n);
        repeat (2)
        begin
            d = 8'($random(seed));
            axi_wr(fct_pkg::ADDR_DISPLAY, {24'h0, d});
            @(posedge aclk);
            check({24'h0, display_port}, {24'h0, d & fct_pkg::DISP_MASK});
        end
        axi_wr(fct_pkg::ADDR_IRQ_MSK, 32'h1);
        far_u.block(1'b0);
        check({31'h0, motor_dir}, 32'h1);
        check({31'h0, irq}, 32'h1);
        axi_rd(fct_pkg::ADDR_STATUS);
        check(rd_v, 32'h1);
        axi_rd(fct_pkg::ADDR_IRQ_ST);
        check(rd_v, 32'h3);
        axi_wr(fct_pkg::ADDR_IRQ_ST, 32'h7);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        axi_wr(fct_pkg::ADDR_IRQ_MSK, 32'h0);
        far_u.block(1'b1);
        check({31'h0, motor_dir}, 32'h0);
        check({31'h0, irq}, 32'h0);
        axi_rd(fct_pkg::ADDR_IRQ_ST);
        check(rd_v, 32'h5);
        axi_rd(8'h40);
        check({30'h0, rsp}, {30'h0, fct_pkg::RESP_SLVERR});
        check(rd_v, 32'h0);
        axi_wr(8'h40, 32'h0);
        check({30'h0, rsp}, {30'h0, fct_pkg::RESP_SLVERR});
        // second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        check({24'h0, display_port}, 32'h0);
        check({31'h0, motor_dir}, 32'h0);
        aresetn <= 1'b1;
        axi_rd(fct_pkg::ADDR_CTRL);
        check(rd_v, 32'h0);
        final_report();
    end
endmodule : tb_top
